//--- hw/mtu_pkg.sv
// Constants for the timer unit: register indices, field positions, masks.
// Assumes a classic Wishbone slave with byte address equal to index times 4.
package mtu_pkg;
  localparam int unsigned ADR_W = 10;
  localparam int unsigned PRE_W = 10;
  localparam int unsigned WT_W = 14;
  localparam int unsigned NUM_FLAGS = 3;
  // Register indices
  localparam logic [7:0] IDX_PORT_MODE_ZERO = 8'hD9;
  localparam logic [7:0] IDX_INTERVAL = 8'hF9;
  localparam logic [7:0] IDX_T1_MODE = 8'hE8;
  localparam logic [7:0] IDX_T1_COMPARE = 8'hE9;
  localparam logic [7:0] IDX_T1_COUNT = 8'hEA;
  localparam logic [7:0] IDX_WATCH_MODE = 8'hEB;
  localparam logic [7:0] IDX_SYS_CLK_MODE = 8'hFA;
  localparam logic [7:0] IDX_PERIPH_CLK_EN = 8'hFB;
  localparam logic [7:0] IDX_FLAGS = 8'hFC;
  localparam logic [7:0] IDX_WATCH_LO = 8'hFD;
  localparam logic [7:0] IDX_WATCH_HI = 8'hFE;
  // Field positions
  localparam int unsigned PERIPHERAL_CLOCK_ENABLE_EN_BIT = 0;
  localparam int unsigned EC_SEL_BIT = 0;
  localparam int unsigned WT_EN_BIT = 3;
  localparam int unsigned WT_SRC_HI = 2;
  localparam int unsigned WT_SRC_LO = 1;
  localparam int unsigned WT_RATE_BIT = 0;
  localparam int unsigned SYSTEM_CLOCK_MODE_SUB_BIT = 1;
  localparam int unsigned FLG_IV = 0;
  localparam int unsigned FLG_T1 = 1;
  localparam int unsigned FLG_WT = 2;
  // Encodings
  localparam logic [1:0] SYSTEM_CLOCK_MODE_MAIN_OFF = 2'h3;
  localparam logic [3:0] IV_DIV_BASE = 4'h3;
  localparam logic [2:0] T1_SRC_EVENT = 3'h0;
  localparam logic [2:0] T1_SRC_MAX = 3'h5;
  localparam logic [1:0] WT_SRC_MAIN = 2'h0;
  localparam logic [13:0] WT_FAST_MASK = 14'h007F;
  localparam logic [13:0] WT_SLOW_MASK = 14'h3FFF;
  localparam logic [7:0] CNT8_MAX = 8'hFF;
  localparam logic [7:0] CNT8_ZERO = 8'h00;
  localparam logic [7:0] CNT8_ONE = 8'h01;
  localparam logic [2:0] EV_SYNC_IDLE = 3'h7;

  // Mask of the n low bits, the prescaler taps for divide by 2^n
  function automatic logic [PRE_W-1:0] ones_below(input logic [3:0] n);
    logic [PRE_W-1:0] m;
    m = '0;
    for (int i = 0; i < PRE_W; i++) begin
      m[i] = (i < int'(n));
    end
    return m;
  endfunction

  // Timer-one source codes 1..5 give divide exponents 1,3,5,7,9
  function automatic logic [3:0] t1_exp(input logic [2:0] code);
    return 4'({1'b0, code, 1'b0} - 4'h1);
  endfunction
endpackage

//--- hw/mtu_timer.sv
// Timer unit: interval timer, timer one / event counter, watch timer.
// Assumes classic Wishbone slave, clock-generator tick strobes on clk_i.
//
// Summary of operation
// RULE1 - Free-running 8-bit interval counter; software cannot halt it. Here, writing 0 to the peripheral clock enable halts it.
// RULE2 - Interval counter wrap from FF to 00 sets the interval flag.
// RULE3 - Three-bit select gives divide 2^3..2^10 of main or sub clock.
// RULE4 - Interval address reads the count, writes the clock select.
// RULE5 - Interval count is offered as the time base output.
// RULE6 - Timer one match with compare sets flag, clears count, continues.
// RULE7 - Timer one counts prescaled clock or external event pulses.
// RULE8 - Source 000 event pin, 001..101 divide 2..2^9, 110/111 invalid.
// RULE9 - Software loads compare with a nonzero value before use.
// RULE10 - Event mode advances on each falling edge of the event pin.
// RULE11 - After a match in event mode, counting resumes on next fall.
// RULE12 - Event pulse rate stays at most half the selected clock.
// RULE13 - Software sets event pin select before using event counting.
// RULE14 - Compare register is not initialised at reset.
// RULE15 - 14-bit watch counter keeps counting in STOP on sub clock.
// RULE16 - Watch mode bit 3 enables the watch counter, clear stops it.
// RULE17 - Watch mode bits 2:1 pick main or sub clock as source.
// RULE18 - Watch mode bit 0 picks 2Hz or 256Hz interrupt rate.
// RULE19 - Watch interrupt releases the device from STOP mode.
// RULE20 - After reset timers get no clock until enable written to one.
// RULE21 - System clock mode 10 selects sub clock, 11 also stops main.
// RULE22 - Timer flags stay set until accepted or cleared by software.
`timescale 1ns/1ps
module mtu_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [mtu_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic main_tick_i,
  input wire logic sub_tick_i,
  input wire logic stop_i,
  input wire logic event_pin_n_i,
  input wire logic [mtu_pkg::NUM_FLAGS-1:0] accept_i,
  output logic [mtu_pkg::NUM_FLAGS-1:0] flags_o,
  output logic [7:0] time_base_o,
  output logic main_osc_off_o,
  output logic stop_wake_o
);
  import mtu_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [7:0] iv_cnt;
    logic [7:0] ckctl;
    logic [7:0] t1_mode;
    logic [7:0] t1_cmp;
    logic [7:0] t1_cnt;
    logic [7:0] port_mode_zero;
    logic [7:0] watch_timer_mode;
    logic [1:0] system_clock_mode;
    logic main_off;
    logic peripheral_clock_enable;
    logic [WT_W-1:0] wt_cnt;
    logic [NUM_FLAGS-1:0] flags;
    logic [2:0] ev_s;
    logic ev_q;
    logic ack;
    logic [7:0] rdat;
    logic wake;
  } mtu_state_t;

  mtu_state_t s_r;
  mtu_state_t s_nxt;

  logic req;
  logic wr_take;
  logic [7:0] idx;
  logic main_run;
  logic src_tick;
  logic [PRE_W-1:0] iv_mask;
  logic iv_tick;
  logic [2:0] t1_src;
  logic [PRE_W-1:0] t1_mask;
  logic ev_fall;
  logic ev_mode_on;
  logic t1_inc;
  logic [7:0] t1_plus;
  logic t1_match;
  logic wt_tick;
  logic [WT_W-1:0] wt_mask;
  logic wt_evt;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_wclr;

  assign req = cyc_i & stb_i;
  assign idx = adr_i[ADR_W-1:2];
  // Write lands on the edge that samples ack
  assign wr_take = req & we_i & s_r.ack & sel_i[0];

  // Main ticks vanish in STOP or once the main oscillator is off
  assign main_run = main_tick_i & ~stop_i & ~s_r.main_off; // [RULE21]
  // Peripheral clock gate and main/sub choice
  assign src_tick = s_r.peripheral_clock_enable &
    (s_r.system_clock_mode[SYSTEM_CLOCK_MODE_SUB_BIT] ? sub_tick_i : main_run); // [RULE20] [RULE3]

  assign iv_mask = ones_below(4'(IV_DIV_BASE + {1'b0, s_r.ckctl[2:0]}));
  assign iv_tick = src_tick & ((s_r.pre & iv_mask) == iv_mask); // [RULE3]

  assign t1_src = s_r.t1_mode[2:0];
  assign t1_mask = ones_below(t1_exp(t1_src));
  // Accepted low level after second and third stages agree
  assign ev_fall = s_r.ev_q & (s_r.ev_s[1] == s_r.ev_s[2]) &
    ~s_r.ev_s[2]; // [RULE10]
  assign ev_mode_on = (t1_src == T1_SRC_EVENT) & s_r.peripheral_clock_enable &
    s_r.port_mode_zero[EC_SEL_BIT]; // [RULE13]
  always_comb begin
    if (t1_src == T1_SRC_EVENT) begin
      t1_inc = ev_mode_on & ev_fall; // [RULE7] [RULE11]
    end else if (t1_src <= T1_SRC_MAX) begin
      t1_inc = src_tick & ((s_r.pre & t1_mask) == t1_mask); // [RULE8]
    end else begin
      t1_inc = 1'b0; // [RULE8]
    end
  end
  assign t1_plus = 8'(s_r.t1_cnt + CNT8_ONE);
  assign t1_match = t1_inc & (t1_plus == s_r.t1_cmp); // [RULE6]

  // Watch source: main ticks or the always-running sub ticks
  assign wt_tick = s_r.peripheral_clock_enable & s_r.watch_timer_mode[WT_EN_BIT] &
    ((s_r.watch_timer_mode[WT_SRC_HI:WT_SRC_LO] == WT_SRC_MAIN) ?
      main_run : sub_tick_i); // [RULE16] [RULE17] [RULE15]
  assign wt_mask = s_r.watch_timer_mode[WT_RATE_BIT] ? WT_FAST_MASK : WT_SLOW_MASK;
  assign wt_evt = wt_tick & ((s_r.wt_cnt & wt_mask) == wt_mask); // [RULE18]

  always_comb begin
    flag_set = '0;
    flag_set[FLG_IV] = iv_tick & (s_r.iv_cnt == CNT8_MAX); // [RULE2]
    flag_set[FLG_T1] = t1_match;
    flag_set[FLG_WT] = wt_evt;
  end
  assign flag_wclr = (wr_take && idx == IDX_FLAGS) ?
    dat_i[NUM_FLAGS-1:0] : '0;

  always_comb begin
    s_nxt = s_r;
    // Synchroniser chain for the event pin
    s_nxt.ev_s = {s_r.ev_s[1:0], event_pin_n_i};
    if (s_r.ev_s[1] == s_r.ev_s[2]) begin
      s_nxt.ev_q = s_r.ev_s[2];
    end
    if (src_tick) begin
      s_nxt.pre = PRE_W'(s_r.pre + 1'b1);
    end
    if (iv_tick) begin
      s_nxt.iv_cnt = 8'(s_r.iv_cnt + CNT8_ONE); // [RULE1] [RULE2]
    end
    if (t1_match) begin
      s_nxt.t1_cnt = CNT8_ZERO; // [RULE6]
    end else if (t1_inc) begin
      s_nxt.t1_cnt = t1_plus;
    end
    if (wt_tick) begin
      s_nxt.wt_cnt = WT_W'(s_r.wt_cnt + 1'b1); // [RULE15]
    end
    // Set wins over accept or software clear
    s_nxt.flags = (s_r.flags & ~(flag_wclr | accept_i)) |
      flag_set; // [RULE22]
    s_nxt.wake = wt_evt & stop_i; // [RULE19]
    s_nxt.main_off = (s_r.system_clock_mode == SYSTEM_CLOCK_MODE_MAIN_OFF); // [RULE21]
    // Register writes
    if (wr_take) begin
      if (idx == IDX_INTERVAL) begin
        s_nxt.ckctl = dat_i[7:0]; // [RULE4]
      end else if (idx == IDX_PORT_MODE_ZERO) begin
        s_nxt.port_mode_zero = dat_i[7:0];
      end else if (idx == IDX_T1_MODE) begin
        s_nxt.t1_mode = dat_i[7:0];
      end else if (idx == IDX_T1_COMPARE) begin
        s_nxt.t1_cmp = dat_i[7:0];
      end else if (idx == IDX_WATCH_MODE) begin
        s_nxt.watch_timer_mode = dat_i[7:0];
      end else if (idx == IDX_SYS_CLK_MODE) begin
        s_nxt.system_clock_mode = dat_i[1:0]; // [RULE21]
      end else if (idx == IDX_PERIPH_CLK_EN) begin
        s_nxt.peripheral_clock_enable = dat_i[PERIPHERAL_CLOCK_ENABLE_EN_BIT]; // [RULE20]
      end
    end
    // Bus answer one cycle after the request
    s_nxt.ack = req & ~s_r.ack;
    if (req && !s_r.ack) begin
      if (idx == IDX_INTERVAL) begin
        s_nxt.rdat = s_r.iv_cnt; // [RULE4]
      end else if (idx == IDX_PORT_MODE_ZERO) begin
        s_nxt.rdat = s_r.port_mode_zero;
      end else if (idx == IDX_T1_MODE) begin
        s_nxt.rdat = s_r.t1_mode;
      end else if (idx == IDX_T1_COMPARE) begin
        s_nxt.rdat = s_r.t1_cmp;
      end else if (idx == IDX_T1_COUNT) begin
        s_nxt.rdat = s_r.t1_cnt;
      end else if (idx == IDX_WATCH_MODE) begin
        s_nxt.rdat = s_r.watch_timer_mode;
      end else if (idx == IDX_SYS_CLK_MODE) begin
        s_nxt.rdat = {6'h00, s_r.system_clock_mode};
      end else if (idx == IDX_PERIPH_CLK_EN) begin
        s_nxt.rdat = {7'h00, s_r.peripheral_clock_enable};
      end else if (idx == IDX_FLAGS) begin
        s_nxt.rdat = {5'h00, s_r.flags};
      end else if (idx == IDX_WATCH_LO) begin
        s_nxt.rdat = s_r.wt_cnt[7:0];
      end else if (idx == IDX_WATCH_HI) begin
        s_nxt.rdat = {2'h0, s_r.wt_cnt[WT_W-1:8]};
      end else begin
        s_nxt.rdat = CNT8_ZERO;
      end
    end
    if (rst_i) begin
      s_nxt = '0;
      s_nxt.ev_s = EV_SYNC_IDLE;
      s_nxt.ev_q = 1'b1;
      s_nxt.t1_cmp = s_r.t1_cmp; // [RULE14]
    end
  end

  always_ff @(posedge clk_i) begin
    s_r <= s_nxt;
  end

  assign dat_o = {24'h000000, s_r.rdat};
  assign ack_o = s_r.ack;
  assign flags_o = s_r.flags;
  assign time_base_o = s_r.iv_cnt; // [RULE5]
  assign main_osc_off_o = s_r.main_off;
  assign stop_wake_o = s_r.wake;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence bus_req_s;
    req && !s_r.ack;
  endsequence
  sequence bus_ack_s;
    s_r.ack ##1 !s_r.ack;
  endsequence
  bus_answer_a: assert property (bus_req_s |=> bus_ack_s)
    else $error("bus request not answered in one cycle");

  interval_wrap_a: assert property ( // [RULE2]
    iv_tick && s_r.iv_cnt == CNT8_MAX |=>
      s_r.iv_cnt == CNT8_ZERO && s_r.flags[FLG_IV])
    else $error("interval wrap did not set flag");

  clock_gate_a: assert property ( // [RULE20]
    !s_r.peripheral_clock_enable |=> $stable(s_r.iv_cnt) && $stable(s_r.t1_cnt) &&
      $stable(s_r.wt_cnt))
    else $error("timer moved without peripheral clock");

  t1_match_clear_a: assert property ( // [RULE6]
    t1_match |=> s_r.t1_cnt == CNT8_ZERO && s_r.flags[FLG_T1])
    else $error("timer one match did not clear and flag");

  invalid_source_a: assert property ( // [RULE8]
    t1_src > T1_SRC_MAX |=> $stable(s_r.t1_cnt))
    else $error("timer one counted on invalid source");

  event_count_a: assert property ( // [RULE10]
    ev_mode_on && ev_fall |=>
      s_r.t1_cnt == 8'($past(s_r.t1_cnt) + CNT8_ONE) ||
      s_r.flags[FLG_T1])
    else $error("event fall not counted");

  watch_stop_a: assert property ( // [RULE16]
    !s_r.watch_timer_mode[WT_EN_BIT] |=> $stable(s_r.wt_cnt))
    else $error("watch counter ran while disabled");

  watch_rate_a: assert property ( // [RULE18]
    wt_tick && s_r.watch_timer_mode[WT_RATE_BIT] &&
      (s_r.wt_cnt & WT_FAST_MASK) == WT_FAST_MASK |=> s_r.flags[FLG_WT])
    else $error("fast watch rate event missed");

  main_off_a: assert property ( // [RULE21]
    s_r.system_clock_mode == SYSTEM_CLOCK_MODE_MAIN_OFF |=> main_osc_off_o ##0 !main_run)
    else $error("main oscillator not turned off");

  flag_hold_a: assert property ( // [RULE22]
    s_r.flags[FLG_T1] && !accept_i[FLG_T1] && !flag_wclr[FLG_T1]
      |=> s_r.flags[FLG_T1])
    else $error("timer one flag lost");

  stop_wake_a: assert property ( // [RULE19]
    wt_evt && stop_i |=> stop_wake_o)
    else $error("watch event did not release stop");

  // Wake pulse only ever follows a watch event seen in STOP
  wake_cause_a: assert property ( // [RULE19]
    stop_wake_o |-> $past(stop_i) && $past(wt_evt))
    else $error("stop release without watch event");

  // Interval counter steps by one per tick and holds otherwise
  interval_step_a: assert property ( // [RULE1]
    iv_tick |=> s_r.iv_cnt == 8'($past(s_r.iv_cnt) + CNT8_ONE))
    else $error("interval counter did not step");

  interval_hold_a: assert property ( // [RULE3]
    !iv_tick |=> $stable(s_r.iv_cnt))
    else $error("interval counter moved without tick");

  // Shared address: reads give the count, writes land in the select
  read_count_a: assert property ( // [RULE4]
    req && !s_r.ack && idx == IDX_INTERVAL |=>
      dat_o[7:0] == $past(s_r.iv_cnt))
    else $error("interval read did not return count");

  select_write_a: assert property ( // [RULE4]
    wr_take && idx == IDX_INTERVAL |=>
      s_r.ckctl == $past(dat_i[7:0]))
    else $error("interval write missed clock select");

  clock_enable_a: assert property ( // [RULE20]
    wr_take && idx == IDX_PERIPH_CLK_EN |=>
      s_r.peripheral_clock_enable == $past(dat_i[PERIPHERAL_CLOCK_ENABLE_EN_BIT]))
    else $error("peripheral clock enable write lost");

  // Timer one steps on its source unless it matches
  t1_advance_a: assert property ( // [RULE7]
    t1_inc && !t1_match |=>
      s_r.t1_cnt == 8'($past(s_r.t1_cnt) + CNT8_ONE))
    else $error("timer one did not advance");

  invalid_flag_a: assert property ( // [RULE8]
    t1_src > T1_SRC_MAX |-> !flag_set[FLG_T1])
    else $error("timer one matched on invalid source");

  // Event mode stays idle until the pin select is set
  event_gate_a: assert property ( // [RULE13]
    t1_src == T1_SRC_EVENT && !ev_mode_on |=> $stable(s_r.t1_cnt))
    else $error("event counted without pin select");

  watch_step_a: assert property ( // [RULE15]
    wt_tick |=> s_r.wt_cnt == WT_W'($past(s_r.wt_cnt) + 1'b1))
    else $error("watch counter did not step");

  // Sub clock keeps the watch counter alive through STOP
  watch_in_stop_a: assert property ( // [RULE15]
    stop_i && sub_tick_i && s_r.peripheral_clock_enable && s_r.watch_timer_mode[WT_EN_BIT] &&
      s_r.watch_timer_mode[WT_SRC_HI:WT_SRC_LO] != WT_SRC_MAIN |=>
      !$stable(s_r.wt_cnt))
    else $error("watch counter halted in stop");

  // Main source has no ticks in STOP
  watch_main_stop_a: assert property ( // [RULE17]
    stop_i && s_r.watch_timer_mode[WT_SRC_HI:WT_SRC_LO] == WT_SRC_MAIN |=>
      $stable(s_r.wt_cnt))
    else $error("watch counted main clock in stop");

  watch_slow_a: assert property ( // [RULE18]
    wt_tick && !s_r.watch_timer_mode[WT_RATE_BIT] &&
      (s_r.wt_cnt & WT_SLOW_MASK) == WT_SLOW_MASK |=> s_r.flags[FLG_WT])
    else $error("slow watch rate event missed");

  // Set beats a same-cycle accept; a lone accept clears
  flag_set_wins_a: assert property ( // [RULE22]
    flag_set[FLG_T1] && accept_i[FLG_T1] |=> s_r.flags[FLG_T1])
    else $error("accept beat timer one flag set");

  flag_accept_a: assert property ( // [RULE22]
    accept_i[FLG_IV] && !flag_set[FLG_IV] |=> !s_r.flags[FLG_IV])
    else $error("accepted interval flag not cleared");
endmodule

//--- dv/mtu_event_src.sv
// Event pulse source on the active-low event pin of the timer unit.
// Assumes the bench clock; the pin idles high as with a pull-up.
`timescale 1ns/1ps
module mtu_event_src (
  input wire logic clk_i,
  output logic event_pin_n_o
);
  initial event_pin_n_o = 1'h1;
  // Each pulse is four cycles low, then four high
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_i);
      event_pin_n_o <= 1'h0;
      repeat (4) @(posedge clk_i);
      event_pin_n_o <= 1'h1;
      repeat (4) @(posedge clk_i);
    end
  endtask
endmodule

//--- dv/test_mtu_timer.sv
// Self-checking bench for the timer unit over classic Wishbone.
// Assumes main tick every cycle and sub tick every second cycle.
`timescale 1ns/1ps
module test_mtu_timer;
  import mtu_pkg::*;
  typedef struct {logic [7:0] a, d, e;} mtu_row_t;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic mt = 1'h1, st = 1'h0, stp = 1'h0;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0] dat = '0, q;
  logic [2:0] acc = 3'h0;
  logic [7:0] v;
  wire logic [31:0] dat_o;
  wire logic ack_o, ev_n, off_o, wake_o;
  wire logic [2:0] flags_o;
  wire logic [7:0] tb_o;
  int bad_count = 0, num_checks = 0, c, i;
  mtu_row_t rows[7] = '{
    '{8'hD9, 8'h01, 8'h01},
    '{8'hE8, 8'h1B, 8'h1B},
    '{8'hE9, 8'h03, 8'h03},
    '{8'hEB, 8'h00, 8'h00},
    '{8'hEA, 8'h55, 8'h00},
    '{8'h10, 8'h77, 8'h00},
    '{8'hF9, 8'h05, 8'h00}};

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) st <= ~st;

  mtu_timer mtu_timer_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack_o), .main_tick_i(mt), .sub_tick_i(st),
    .stop_i(stp), .event_pin_n_i(ev_n), .accept_i(acc),
    .flags_o(flags_o), .time_base_o(tb_o), .main_osc_off_o(off_o),
    .stop_wake_o(wake_o));
  mtu_event_src mtu_event_src_i (.clk_i(clk_i), .event_pin_n_o(ev_n));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // One classic cycle; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {a, 2'h0};
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && n < 50);
    q = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk_i);
    if (n >= 50) begin
      chk("bus timeout", 1, 0);
      end_of_test();
    end
  endtask

  function automatic logic [7:0] obs(input int s);
    if (s == 0) return tb_o;
    return {7'h0, s < 4 ? flags_o[s-1] : wake_o};
  endfunction

  // Cycles between two successive events of the watched signal, into c
  task automatic gap(input int s);
    logic [7:0] p;
    for (int k = 0; k < 2; k++) begin
      c = 0;
      do begin
        p = obs(s);
        @(posedge clk_i);
        c++;
      end while (c < 9000 && (obs(s) === p || (s > 0 && obs(s) !== 8'h1)));
      if (c >= 9000) begin
        chk("wait timeout", 1, 0);
        end_of_test();
      end
    end
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    chk("reset outs", 0, {flags_o, tb_o, ack_o, off_o, wake_o});
    rst_i <= 1'h0;
    repeat (30) @(posedge clk_i);
    chk("gated count", 0, tb_o);
    foreach (rows[j]) begin
      bus(1'h1, rows[j].a, rows[j].d);
      bus(1'h0, rows[j].a, 8'h00);
      chk("reg read", rows[j].e, q);
    end
    bus(1'h1, IDX_PERIPH_CLK_EN, 8'h01);
    for (i = 0; i < 8; i++) begin
      bus(1'h1, IDX_INTERVAL, 8'(i));
      gap(0);
      chk("interval gap", 8 << i, c);
    end
    bus(1'h1, IDX_INTERVAL, 8'h00);
    bus(1'h1, IDX_SYS_CLK_MODE, 8'h02);
    gap(0);
    chk("sub interval gap", 16, c);
    bus(1'h1, IDX_SYS_CLK_MODE, 8'h03);
    @(posedge clk_i);
    chk("main off", 1, off_o);
    bus(1'h1, IDX_SYS_CLK_MODE, 8'h00);
    @(posedge clk_i);
    chk("main on", 0, off_o);
    acc <= 3'h7;
    gap(1);
    chk("overflow gap", 2048, c);
    acc <= 3'h0;
    repeat (2100) @(posedge clk_i);
    bus(1'h1, IDX_PERIPH_CLK_EN, 8'h00);
    repeat (50) @(posedge clk_i);
    chk("flag held", 1, flags_o[0]);
    bus(1'h1, IDX_FLAGS, 8'h01);
    chk("flag cleared", 0, flags_o[0]);
    bus(1'h1, IDX_PERIPH_CLK_EN, 8'h01);
    acc <= 3'h7;
    for (i = 1; i < 6; i++) begin
      bus(1'h1, IDX_T1_MODE, 8'(i));
      gap(2);
      chk("t1 gap", 3 << (2 * i - 1), c);
    end
    acc <= 3'h0;
    bus(1'h1, IDX_T1_MODE, 8'h00);
    bus(1'h1, IDX_FLAGS, 8'h07);
    bus(1'h0, IDX_T1_COUNT, 8'h00);
    mtu_event_src_i.pulse(3 - int'(q[7:0]));
    bus(1'h0, IDX_T1_COUNT, 8'h00);
    chk("event match", 9'h100, {flags_o[1], q[7:0]});
    mtu_event_src_i.pulse(2);
    bus(1'h0, IDX_T1_COUNT, 8'h00);
    chk("event resume", 2, q);
    bus(1'h1, IDX_T1_MODE, 8'h06);
    bus(1'h1, IDX_FLAGS, 8'h02);
    mtu_event_src_i.pulse(4);
    repeat (64) @(posedge clk_i);
    bus(1'h0, IDX_T1_COUNT, 8'h00);
    chk("invalid source", 9'h002, {flags_o[1], q[7:0]});
    acc <= 3'h7;
    bus(1'h1, IDX_WATCH_MODE, 8'h0B);
    gap(3);
    chk("watch gap", 256, c);
    stp <= 1'h1;
    gap(4);
    chk("stop wake gap", 256, c);
    stp <= 1'h0;
    bus(1'h1, IDX_WATCH_MODE, 8'h03);
    bus(1'h0, IDX_WATCH_LO, 8'h00);
    v = q[7:0];
    repeat (300) @(posedge clk_i);
    bus(1'h0, IDX_WATCH_LO, 8'h00);
    chk("watch halted", v, q);
    end_of_test();
  end
endmodule
